// *** rtl/acg_pkg.sv ***
// package for the auxiliary control write gating block
// assumes one core clock and a plain register port
package acg_pkg;

  // =====================================================
  // register port geometry and offsets (word index)
  localparam int unsigned DATA_W = 64;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_AUX_EL1   = 4'h0;
  localparam logic [3:0] OFS_AUX_EL2   = 4'h1;
  localparam logic [3:0] OFS_AUX_EL3   = 4'h2;
  localparam logic [3:0] OFS_FAULT0    = 4'h3;
  localparam logic [3:0] OFS_IRQ_STAT  = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK  = 4'h5;
  localparam logic [3:0] OFS_TRAP_CNT  = 4'h6;
  localparam logic [3:0] OFS_TRAP_INFO = 4'h7;

  // =====================================================
  // field positions of the el2 and el3 registers
  localparam int unsigned BIT_TRAP_AMU = 30;
  localparam int unsigned NUM_GROUPS   = 8;
  // write enable bit per target group, indexed by group code
  localparam int unsigned GROUP_BIT [NUM_GROUPS] =
    '{12, 11, 10, 7, 6, 5, 1, 0};
  // implemented bits; everything else reads zero
  localparam logic [63:0] AUX_WR_MASK = 64'h0000_0000_4000_1CE3;
  localparam logic [63:0] AUX_RESET   = 64'h0000_0000_0000_0000;

  // =====================================================
  // interrupt status layout
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_TRAP_EL2 = 0;
  localparam int unsigned IRQ_TRAP_EL3 = 1;
  localparam int unsigned IRQ_DENIED   = 2;

  // =====================================================
  // types
  typedef enum logic [1:0] {
    EL0 = 2'h0, EL1 = 2'h1, EL2 = 2'h2, EL3 = 2'h3
  } acg_el_t;

  typedef enum logic [2:0] {
    GRP_PERFMON  = 3'h0, GRP_SCHEME   = 3'h1,
    GRP_THREAD   = 3'h2, GRP_POWER    = 3'h3,
    GRP_LOCKOUT  = 3'h4, GRP_ERR_INJ  = 3'h5,
    GRP_EXT_CTRL = 3'h6, GRP_AUX_CTRL = 3'h7
  } acg_group_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    acg_el_t    el;
    logic       nsec;
    logic       amu;
    acg_group_t group;
  } acg_req_t;

  typedef struct packed {
    logic allow;
    logic trap_el2;
    logic trap_el3;
    logic denied;
  } acg_resp_t;

endpackage : acg_pkg

// *** rtl/acg_gate_eval.sv ***
// combinational access decision for one lower-level request
// assumes request and control words are stable in the cycle
`timescale 1ns/1ps
module acg_gate_eval (
  input  wire logic [63:0]       aux_el2,
  input  wire logic [63:0]       aux_el3,
  input  wire acg_pkg::acg_req_t req,
  output acg_pkg::acg_resp_t     resp
);

  logic [acg_pkg::NUM_GROUPS-1:0] sec_grant;
  logic [acg_pkg::NUM_GROUPS-1:0] ns_grant;
  logic amu2;
  logic amu3;
  logic lower_sec;
  logic ok;

  // =====================================================
  // per group grants: el3 copy first, el2 copy on top
  // lockout group needs both copies, also for el2 and secure el1
  for (genvar i = 0; i < acg_pkg::NUM_GROUPS; i++) begin : g_grp
    if (i == int'(acg_pkg::GRP_LOCKOUT)) begin : g_both
      assign sec_grant[i] = aux_el3[acg_pkg::GROUP_BIT[i]] &
                            aux_el2[acg_pkg::GROUP_BIT[i]];
    end else begin : g_el3
      assign sec_grant[i] = aux_el3[acg_pkg::GROUP_BIT[i]];
    end
    assign ns_grant[i]  = aux_el3[acg_pkg::GROUP_BIT[i]] &
                          aux_el2[acg_pkg::GROUP_BIT[i]];
  end

  // activity monitor traps, el2 trap wins for el1 and el0
  assign amu2 = req.amu & aux_el2[acg_pkg::BIT_TRAP_AMU] &
                (req.el == acg_pkg::EL0 || req.el == acg_pkg::EL1);
  assign amu3 = req.amu & aux_el3[acg_pkg::BIT_TRAP_AMU] &
                (req.el != acg_pkg::EL3) & ~amu2;

  assign lower_sec = (req.el == acg_pkg::EL2) |
                     (req.el == acg_pkg::EL1 && !req.nsec);

  // decision for writes to a gated group
  always_comb begin
    ok = 1'b0;
    if (req.el == acg_pkg::EL3) begin
      ok = 1'b1;
    end else if (lower_sec) begin
      ok = sec_grant[req.group];
    end else if (req.el == acg_pkg::EL1) begin
      ok = ns_grant[req.group];
    end
  end

  assign resp.denied   = ~req.amu & req.write & ~ok;
  assign resp.allow    = ~(amu2 | amu3) & ~resp.denied;
  assign resp.trap_el2 = amu2 |
                         (resp.denied & sec_grant[req.group]);
  assign resp.trap_el3 = amu3 |
                         (resp.denied & ~sec_grant[req.group]);

endmodule : acg_gate_eval

// *** rtl/acg_irq.sv ***
// sticky event status, mask and level interrupt
// assumes one-cycle event pulses on the core clock
`timescale 1ns/1ps
module acg_irq #(
  parameter int unsigned N = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] evt,
  input  wire logic         wr_stat,
  input  wire logic         wr_mask,
  input  wire logic [N-1:0] wdata,
  output logic      [N-1:0] stat_reg,
  output logic      [N-1:0] mask_reg,
  output logic              irq_reg
);

  // sticky bits, a new event beats a write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~(wr_stat ? wdata : '0)) | evt;
    end
  end

  // mask register, one enables the bit
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_reg <= '0;
    end else if (wr_mask) begin
      mask_reg <= wdata;
    end
  end

  // level interrupt from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

endmodule : acg_irq

// *** rtl/acg_top.sv ***
// auxiliary control registers and lower-level write gating
// assumes a plain register port and one request per cycle
//
// Operation
// - el1 auxiliary control is 64 reserved bits reading zero
// - el2 bit 30 traps el1 and el0 monitor accesses to el2
// - el3 bit 30 traps el2 monitor accesses to el3, el1 and el0 ones when el2 bit 30 is clear
// - bit 12 gates cluster perfmon writes, el3 then el2 copy
// - bit 11 gates scheme id, partition and qos writes
// - bit 10 gates cluster thread scheme id writes
// - bit 7 gates core and cluster power and l3 counter writes
// - bit 6 gates line lockout control and lockout registers
// - bit 5 gates pseudo fault generation register writes
// - bit 1 gates core and cluster extended control writes
// - bit 0 gates core and cluster auxiliary control writes
// - all trap and enable fields reset to zero
// - auxiliary fault status 0 at el1 is unused, reads zero
`timescale 1ns/1ps
module acg_top #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic              MCLK,
  input  wire logic              RST,
  // register port
  input  wire logic [3:0]        ADDR,
  input  wire logic [63:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [63:0]       RDATA,
  // lower-level access check
  input  wire acg_pkg::acg_req_t ACC_REQ,
  output logic                   ACC_DONE,
  output logic                   ACC_ALLOW,
  output logic                   ACC_TRAP_EL2,
  output logic                   ACC_TRAP_EL3,
  // control levels for the core
  output logic                   AMU_TRAP_EL2,
  output logic                   AMU_TRAP_EL3,
  output logic [7:0]             WR_EN_SECURE,
  output logic [7:0]             WR_EN_NONSEC,
  // interrupt
  output logic                   IRQ
);

  // =====================================================
  // elaboration checks
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
    $error("trap counter width must be 1 to 32");
  end
  if (acg_pkg::NUM_GROUPS != 8) begin : g_bad_grp
    $error("group count must match the enable port width");
  end

  // =====================================================
  // declarations
  logic [63:0]              aux_el2_reg;
  logic [63:0]              aux_el3_reg;
  logic [63:0]              rdata_reg;
  logic [63:0]              rdata_next;
  logic                     rd_q_reg;
  logic                     done_reg;
  logic                     allow_reg;
  logic                     trap2_reg;
  logic                     trap3_reg;
  logic [CNT_W-1:0]         trap_cnt_reg;
  logic [15:0]              trap_info_reg;
  logic [7:0]               en_sec_reg;
  logic [7:0]               en_ns_reg;
  acg_pkg::acg_resp_t       dec;
  logic                     take;
  logic                     trapped;
  logic                     wr_el2;
  logic                     wr_el3;
  logic                     wr_cnt;
  logic                     wr_stat;
  logic                     wr_mask;
  logic [acg_pkg::IRQ_W-1:0] evt;
  logic [acg_pkg::IRQ_W-1:0] stat;
  logic [acg_pkg::IRQ_W-1:0] mask;
  logic                     irq_q;

  // =====================================================
  // register write decode
  assign wr_el2  = WR && ADDR == acg_pkg::OFS_AUX_EL2;
  assign wr_el3  = WR && ADDR == acg_pkg::OFS_AUX_EL3;
  assign wr_cnt  = WR && ADDR == acg_pkg::OFS_TRAP_CNT;
  assign wr_stat = WR && ADDR == acg_pkg::OFS_IRQ_STAT;
  assign wr_mask = WR && ADDR == acg_pkg::OFS_IRQ_MASK;

  // el2 control word
  always_ff @(posedge MCLK) begin
    if (RST) begin
      aux_el2_reg <= acg_pkg::AUX_RESET;
    end else if (wr_el2) begin
      aux_el2_reg <= WDATA & acg_pkg::AUX_WR_MASK;
    end
  end

  // el3 control word
  always_ff @(posedge MCLK) begin
    if (RST) begin
      aux_el3_reg <= acg_pkg::AUX_RESET;
    end else if (wr_el3) begin
      aux_el3_reg <= WDATA & acg_pkg::AUX_WR_MASK;
    end
  end

  // =====================================================
  // access decision
  acg_gate_eval u_gate (
    .aux_el2 (aux_el2_reg),
    .aux_el3 (aux_el3_reg),
    .req     (ACC_REQ),
    .resp    (dec)
  );

  assign take    = ACC_REQ.valid;
  assign trapped = dec.trap_el2 | dec.trap_el3;

  // registered answer, one cycle after the request
  always_ff @(posedge MCLK) begin
    if (RST) begin
      done_reg  <= 1'b0;
      allow_reg <= 1'b0;
    end else begin
      done_reg  <= take;
      allow_reg <= take & dec.allow;
    end
  end

  // trap targets of the answer
  always_ff @(posedge MCLK) begin
    if (RST) begin
      trap2_reg <= 1'b0;
      trap3_reg <= 1'b0;
    end else begin
      trap2_reg <= take & dec.trap_el2;
      trap3_reg <= take & dec.trap_el3;
    end
  end

  // =====================================================
  // per group enable levels for the target registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      en_sec_reg <= '0;
      en_ns_reg  <= '0;
    end else begin
      for (int i = 0; i < acg_pkg::NUM_GROUPS; i++) begin
        // each group: el3 bit, plus el2 bit for the lockout group (bit 6) and nonsecure
        en_sec_reg[i] <= aux_el3_reg[acg_pkg::GROUP_BIT[i]] &
                         (aux_el2_reg[acg_pkg::GROUP_BIT[i]] |
                          (i != int'(acg_pkg::GRP_LOCKOUT)));
        en_ns_reg[i]  <= aux_el3_reg[acg_pkg::GROUP_BIT[i]] &
                         aux_el2_reg[acg_pkg::GROUP_BIT[i]];
      end
    end
  end

  // monitor trap levels
  always_ff @(posedge MCLK) begin
    if (RST) begin
      AMU_TRAP_EL2 <= 1'b0;
      AMU_TRAP_EL3 <= 1'b0;
    end else begin
      AMU_TRAP_EL2 <= aux_el2_reg[acg_pkg::BIT_TRAP_AMU];
      AMU_TRAP_EL3 <= aux_el3_reg[acg_pkg::BIT_TRAP_AMU];
    end
  end

  // =====================================================
  // trap statistics
  always_ff @(posedge MCLK) begin
    if (RST) begin
      trap_cnt_reg <= '0;
    end else if (take && trapped) begin
      // a trap in the clear cycle still counts
      if (wr_cnt) begin
        trap_cnt_reg <= CNT_W'(1);
      end else if (~&trap_cnt_reg) begin
        trap_cnt_reg <= trap_cnt_reg + CNT_W'(1);
      end
    end else if (wr_cnt) begin
      trap_cnt_reg <= '0;
    end
  end

  // last trapped request: el, security, write, monitor, group
  always_ff @(posedge MCLK) begin
    if (RST) begin
      trap_info_reg <= '0;
    end else if (take && trapped) begin
      trap_info_reg <= {7'h00, dec.trap_el3, ACC_REQ.el,
                        ACC_REQ.nsec, ACC_REQ.write,
                        ACC_REQ.amu, ACC_REQ.group};
    end
  end

  // =====================================================
  // interrupt events and controller
  assign evt[acg_pkg::IRQ_TRAP_EL2] = take & dec.trap_el2;
  assign evt[acg_pkg::IRQ_TRAP_EL3] = take & dec.trap_el3;
  assign evt[acg_pkg::IRQ_DENIED]   = take & dec.denied;

  acg_irq #(
    .N (acg_pkg::IRQ_W)
  ) u_irq (
    .clk      (MCLK),
    .rst      (RST),
    .evt      (evt),
    .wr_stat  (wr_stat),
    .wr_mask  (wr_mask),
    .wdata    (WDATA[acg_pkg::IRQ_W-1:0]),
    .stat_reg (stat),
    .mask_reg (mask),
    .irq_reg  (irq_q)
  );

  // =====================================================
  // read mux
  always_comb begin
    rdata_next = '0;
    case (ADDR)
      acg_pkg::OFS_AUX_EL1:   rdata_next = '0;
      acg_pkg::OFS_AUX_EL2:   rdata_next = aux_el2_reg;
      acg_pkg::OFS_AUX_EL3:   rdata_next = aux_el3_reg;
      acg_pkg::OFS_FAULT0:    rdata_next = '0;
      acg_pkg::OFS_IRQ_STAT:  rdata_next[acg_pkg::IRQ_W-1:0] = stat;
      acg_pkg::OFS_IRQ_MASK:  rdata_next[acg_pkg::IRQ_W-1:0] = mask;
      acg_pkg::OFS_TRAP_CNT:  rdata_next[CNT_W-1:0] = trap_cnt_reg;
      acg_pkg::OFS_TRAP_INFO: rdata_next[15:0] = trap_info_reg;
      default:                rdata_next = '0;
    endcase
  end

  // read data held for the cycle after the strobe only
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_reg <= '0;
      rd_q_reg  <= 1'b0;
    end else begin
      rdata_reg <= RD ? rdata_next : '0;
      rd_q_reg  <= RD;
    end
  end

  // =====================================================
  // outputs straight from flops
  assign RDATA        = rdata_reg;
  assign ACC_DONE     = done_reg;
  assign ACC_ALLOW    = allow_reg;
  assign ACC_TRAP_EL2 = trap2_reg;
  assign ACC_TRAP_EL3 = trap3_reg;
  assign WR_EN_SECURE = en_sec_reg;
  assign WR_EN_NONSEC = en_ns_reg;
  assign IRQ          = irq_q;

endmodule : acg_top

// *** dv/acg_top_asserts.sv ***
// checker for the write gating block ports
// assumes it is bound to every acg_top instance
`timescale 1ns/1ps
module acg_top_asserts (
  input wire logic              MCLK,
  input wire logic              RST,
  input wire logic [3:0]        ADDR,
  input wire logic              RD,
  input wire logic              WR,
  input wire logic [63:0]       RDATA,
  input wire acg_pkg::acg_req_t ACC_REQ,
  input wire logic              ACC_DONE,
  input wire logic              ACC_ALLOW,
  input wire logic              ACC_TRAP_EL2,
  input wire logic              ACC_TRAP_EL3,
  input wire logic              AMU_TRAP_EL2,
  input wire logic              AMU_TRAP_EL3,
  input wire logic [7:0]        WR_EN_SECURE,
  input wire logic [7:0]        WR_EN_NONSEC,
  input wire logic              IRQ
);
  // plain write request, no monitor access
  wire req_w = ACC_REQ.valid && ACC_REQ.write && !ACC_REQ.amu;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  // =====================================================
  // access answers
  chk_done_next: assert property (ACC_REQ.valid |=> ACC_DONE)
    else $error("access request left unanswered");
  chk_one_verdict:
    assert property (ACC_DONE |->
      $onehot({ACC_ALLOW, ACC_TRAP_EL2, ACC_TRAP_EL3}))
    else $error("access answer is not one verdict");
  chk_amu_el2:
    assert property (ACC_REQ.valid && ACC_REQ.amu && !$past(WR) &&
      ACC_REQ.el <= acg_pkg::EL1 && AMU_TRAP_EL2 |=> ACC_TRAP_EL2)
    else $error("monitor access not trapped to el2");
  chk_amu_el3:
    assert property (ACC_REQ.valid && ACC_REQ.amu && !$past(WR) &&
      ACC_REQ.el != acg_pkg::EL3 && AMU_TRAP_EL3 && !AMU_TRAP_EL2
      |=> ACC_TRAP_EL3)
    else $error("monitor access not trapped to el3");
  chk_wr_secure:
    assert property (req_w && !$past(WR) && (ACC_REQ.el == acg_pkg::EL2 ||
      ACC_REQ.el == acg_pkg::EL1 && !ACC_REQ.nsec)
      |=> ACC_ALLOW == $past(WR_EN_SECURE[ACC_REQ.group]))
    else $error("secure write verdict differs from enable");
  chk_wr_nonsec:
    assert property (req_w && !$past(WR) && ACC_REQ.nsec &&
      ACC_REQ.el == acg_pkg::EL1
      |=> ACC_ALLOW == $past(WR_EN_NONSEC[ACC_REQ.group]))
    else $error("nonsecure write verdict differs from enable");

  // =====================================================
  // reset and read values
  chk_reset_zero:
    assert property ($fell(RST) |-> {WR_EN_SECURE, WR_EN_NONSEC,
      AMU_TRAP_EL2, AMU_TRAP_EL3, IRQ} == 19'h0)
    else $error("controls not zero after reset");
  chk_raz_regs:
    assert property ($past(RD) && ($past(ADDR) == acg_pkg::OFS_AUX_EL1 ||
      $past(ADDR) == acg_pkg::OFS_FAULT0) |-> RDATA == 64'h0)
    else $error("unused register reads nonzero");
  chk_rsvd_zero:
    assert property ($past(RD) && ($past(ADDR) == acg_pkg::OFS_AUX_EL2 ||
      $past(ADDR) == acg_pkg::OFS_AUX_EL3)
      |-> (RDATA & ~acg_pkg::AUX_WR_MASK) == 64'h0)
    else $error("reserved control bits read nonzero");

  // main scenarios reached
  cov_trap_el2: cover property (ACC_TRAP_EL2);
  cov_trap_el3: cover property (ACC_TRAP_EL3);
  cov_allow_wr: cover property (req_w ##1 ACC_ALLOW);
  cov_irq: cover property (IRQ);
endmodule : acg_top_asserts

bind acg_top acg_top_asserts u_acg_top_asserts (
  .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .RD(RD), .WR(WR),
  .RDATA(RDATA), .ACC_REQ(ACC_REQ), .ACC_DONE(ACC_DONE),
  .ACC_ALLOW(ACC_ALLOW), .ACC_TRAP_EL2(ACC_TRAP_EL2),
  .ACC_TRAP_EL3(ACC_TRAP_EL3), .AMU_TRAP_EL2(AMU_TRAP_EL2),
  .AMU_TRAP_EL3(AMU_TRAP_EL3), .WR_EN_SECURE(WR_EN_SECURE),
  .WR_EN_NONSEC(WR_EN_NONSEC), .IRQ(IRQ)
);

// *** dv/acg_top_test.sv ***
// self-checking bench for the write gating block
// assumes the checker is compiled beside the design
`timescale 1ns/1ps
module acg_top_test;
  logic              MCLK = 1'b0;
  logic              RST = 1'b1;
  logic [3:0]        ADDR = 4'h0;
  logic [63:0]       WDATA = 64'h0;
  logic              WR = 1'b0;
  logic              RD = 1'b0;
  acg_pkg::acg_req_t ACC_REQ = '0;
  logic [63:0]       RDATA, rd_val, cfg2, cfg3;
  logic              ACC_DONE, ACC_ALLOW, ACC_TRAP_EL2, ACC_TRAP_EL3;
  logic              AMU_TRAP_EL2, AMU_TRAP_EL3, IRQ;
  logic [7:0]        WR_EN_SECURE, WR_EN_NONSEC;
  int                n_fail = 0;
  int                n_compared = 0;

  // 50 MHz core clock
  always #10 MCLK = ~MCLK;

  acg_top u_acg_top (
    .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .ACC_REQ(ACC_REQ), .ACC_DONE(ACC_DONE),
    .ACC_ALLOW(ACC_ALLOW), .ACC_TRAP_EL2(ACC_TRAP_EL2),
    .ACC_TRAP_EL3(ACC_TRAP_EL3), .AMU_TRAP_EL2(AMU_TRAP_EL2),
    .AMU_TRAP_EL3(AMU_TRAP_EL3), .WR_EN_SECURE(WR_EN_SECURE),
    .WR_EN_NONSEC(WR_EN_NONSEC), .IRQ(IRQ)
  );

  // =====================================================
  // bus, compare and expectation helpers
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(logic [3:0] a, logic [63:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(logic [3:0] a);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    rd_val = RDATA;
  endtask : reg_rd

  task automatic set_cfg(logic [63:0] a, logic [63:0] b);
    cfg2 = a;
    cfg3 = b;
    reg_wr(acg_pkg::OFS_AUX_EL2, a);
    reg_wr(acg_pkg::OFS_AUX_EL3, b);
  endtask : set_cfg

  // requester r: 0 el0, 1 nonsecure el1, 2 secure el1, 3 el2, 4 el3
  function automatic logic [2:0] model(int r, logic amu, logic wr, int b);
    logic ok;
    logic sec;
    if (amu && r <= 2 && cfg2[30]) return 3'h2;
    if (amu && r != 4 && cfg3[30]) return 3'h1;
    if (amu || !wr || r == 4) return 3'h4;
    // lockout group is gated by both copies for secure writers
    sec = cfg3[b] && (cfg2[b] ||
          b != acg_pkg::GROUP_BIT[acg_pkg::GRP_LOCKOUT]);
    ok = (r >= 2) ? sec : (r == 1 && cfg3[b] && cfg2[b]);
    return ok ? 3'h4 : (sec ? 3'h2 : 3'h1);
  endfunction : model

  task automatic acc(int r, logic amu, logic wr, int g, logic [2:0] exp);
    acg_pkg::acg_req_t q;
    q = '0;
    q.valid = 1'b1;
    q.write = wr;
    q.amu = amu;
    q.nsec = (r == 1);
    q.group = acg_pkg::acg_group_t'(3'(g));
    q.el = acg_pkg::acg_el_t'(2'(r == 0 ? 0 : (r <= 2 ? 1 : r - 1)));
    @(posedge MCLK);
    ACC_REQ <= q;
    @(posedge MCLK);
    ACC_REQ <= '0;
    @(negedge MCLK);
    chk("verdict", {60'h1, exp},
        {ACC_DONE, ACC_ALLOW, ACC_TRAP_EL2, ACC_TRAP_EL3});
  endtask : acc

  // =====================================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 16; i++) begin
      reg_rd(4'(i));
      chk("reset read", 64'h0, rd_val);
    end
    chk("reset ctl", 64'h0, {WR_EN_SECURE, WR_EN_NONSEC, IRQ});
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    for (int i = 0; i < 4; i++) reg_wr(4'(i), '1);
    reg_wr(4'hF, '1);
    for (int i = 0; i < 4; i++) begin
      reg_rd(4'(i));
      chk("aux word", (i == 1 || i == 2) ? acg_pkg::AUX_WR_MASK : 64'h0,
          rd_val);
    end
    reg_rd(4'hF);
    chk("unmapped", 64'h0, rd_val);
    chk("ctl ports", 64'h3FFFF, {AMU_TRAP_EL2, AMU_TRAP_EL3,
        WR_EN_SECURE, WR_EN_NONSEC});
    $display("test registers done");
  endtask : t_regs

  task automatic t_groups();
    logic [63:0] on;
    int b;
    for (int g = 0; g < 8; g++) begin
      b = acg_pkg::GROUP_BIT[g];
      on = 64'h1 << b;
      for (int c = 0; c < 4; c++) begin
        // other groups get the opposite setting
        set_cfg(c[0] ? on : acg_pkg::AUX_WR_MASK & ~on,
                c[1] ? on : acg_pkg::AUX_WR_MASK & ~on);
        for (int r = 0; r < 10; r++)
          acc(r / 2, 1'b0, r[0], g, model(r / 2, 1'b0, r[0], b));
        chk("enables", {62'h0, c[1] & (c[0] | g != acg_pkg::GRP_LOCKOUT),
            c[1] & c[0]},
            {WR_EN_SECURE[g], WR_EN_NONSEC[g]});
      end
    end
    $display("test groups done");
  endtask : t_groups

  task automatic t_amu();
    for (int c = 0; c < 4; c++) begin
      set_cfg(64'(c[0]) << 30, 64'(c[1]) << 30);
      for (int r = 0; r < 5; r++)
        acc(r, 1'b1, r[0], 0, model(r, 1'b1, r[0], 0));
    end
    $display("test monitor traps done");
  endtask : t_amu

  task automatic t_irq();
    reg_wr(acg_pkg::OFS_IRQ_STAT, 64'h7);
    reg_wr(acg_pkg::OFS_IRQ_MASK, 64'h0);
    reg_wr(acg_pkg::OFS_TRAP_CNT, 64'h0);
    set_cfg(64'h0, 64'h0);
    acc(1, 1'b0, 1'b1, 7, 3'h1);
    reg_rd(acg_pkg::OFS_IRQ_STAT);
    chk("status", 64'h6, rd_val);
    reg_rd(acg_pkg::OFS_TRAP_CNT);
    chk("trap count", 64'h1, rd_val);
    reg_rd(acg_pkg::OFS_TRAP_INFO);
    chk("trap info", 64'h177, rd_val);
    chk("masked irq", 64'h0, IRQ);
    reg_wr(acg_pkg::OFS_IRQ_MASK, 64'h7);
    reg_rd(acg_pkg::OFS_IRQ_MASK);
    chk("mask", 64'h7, rd_val);
    chk("irq", 64'h1, IRQ);
    reg_wr(acg_pkg::OFS_IRQ_STAT, 64'h6);
    reg_rd(acg_pkg::OFS_IRQ_STAT);
    chk("cleared", 64'h0, {rd_val[2:0], IRQ});
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_rerst();
    set_cfg('1, '1);
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    reg_rd(acg_pkg::OFS_AUX_EL2);
    chk("el2 after reset", 64'h0, rd_val);
    reg_rd(acg_pkg::OFS_AUX_EL3);
    chk("el3 after reset", 64'h0, rd_val);
    acc(3, 1'b1, 1'b0, 0, 3'h4);
    $display("test second reset done");
  endtask : t_rerst

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    t_reset();
    t_regs();
    t_groups();
    t_amu();
    t_irq();
    t_rerst();
    end_of_test();
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge MCLK);
    n_fail++;
    end_of_test();
  end
endmodule : acg_top_test
